// File: podc_pkg.sv
/*
 * Package for the port A and open-drain pad control block.
 * Holds register offsets, field positions, reset values and packed carriers.
 * Assumes nothing of its surroundings.
 */
package podc_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [3:0] OFS_OD_SERIAL_CAPTURE = 4'h0;
   localparam logic [3:0] OFS_OD_CAPTURE_UNITS  = 4'h1;
   localparam logic [3:0] OFS_OD_UART_PULSE     = 4'h2;
   localparam logic [3:0] OFS_PORT_A_PINS       = 4'h3;
   localparam logic [3:0] OFS_PORT_A_LATCH      = 4'h4;
   localparam logic [3:0] OFS_PORT_A_DIR        = 4'h5;
   localparam logic [3:0] OFS_ANALOG_SEL1       = 4'h6;
   localparam logic [3:0] OFS_CLOCK_CFG         = 4'h7;

   // ****************************************************************
   // Field positions and masks
   // ****************************************************************
   localparam int SER1_BIT  = 7;
   localparam int CAP2_BIT  = 6;
   localparam int CAP1_BIT  = 5;
   localparam int SER2_BIT  = 0;
   localparam int UART2_BIT = 7;
   localparam int UART1_BIT = 6;
   localparam int PDLY_BIT  = 0;
   localparam int CLK_TIMER1_BIT = 0;
   localparam int CLK_TIMER3_BIT = 1;

   localparam logic [7:0] OD1_MASK       = 8'he1;
   localparam logic [7:0] OD2_MASK_FULL  = 8'hff;
   localparam logic [7:0] OD2_MASK_SMALL = 8'h3f;
   localparam logic [7:0] OD3_MASK       = 8'hc1;
   localparam logic [7:0] ANALOG_A_MASK  = 8'h2f;
   localparam logic [7:0] OSC_PINS_MASK  = 8'hc0;
   localparam logic [7:0] CLK_CFG_MASK   = 8'h03;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0] OD_RESET      = 8'h00;
   localparam logic [7:0] DIR_RESET     = 8'hff;
   localparam logic [7:0] LATCH_RESET   = 8'h00;
   localparam logic [7:0] ANALOG_RESET  = 8'h2f;
   localparam logic [7:0] CLK_CFG_RESET = 8'h00;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic       read;
      logic       write;
      logic [3:0] address;
      logic [7:0] writedata;
   } podc_req_t;

   typedef struct packed {
      logic       sync_serial1;
      logic       sync_serial2;
      logic       capture1;
      logic       capture2;
      logic [7:0] capture10_3;
      logic       uart1;
      logic       uart2;
   } podc_periph_t;

endpackage : podc_pkg

// File: podc_od_pad.sv
/*
 * One peripheral output pad with a selectable open-drain mode.
 * Assumes the board supplies a pull-up wherever open-drain mode is used.
 */
`timescale 1ns/1ps
module podc_od_pad
   import podc_pkg::*;
(
   input  wire logic od_en,
   input  wire logic data,
   input  wire logic drive_en,
   output logic      pad_out,
   output logic      pad_oe
);

   // ****************************************************************
   // Drive selection
   // ****************************************************************
   // A high in open-drain mode is left to the external pull-up.
   always_comb
   begin
      pad_out = od_en ? 1'b0 : data;
      pad_oe  = drive_en & (od_en ? ~data : 1'b1);
   end

endmodule : podc_od_pad

// File: podc_port_pin.sv
/*
 * One port A pin: direction, latch drive, analog gating and read-back.
 * Assumes pin inputs are synchronous to the clock.
 */
`timescale 1ns/1ps
module podc_port_pin
   import podc_pkg::*;
(
   input  wire logic dir_in,
   input  wire logic latch,
   input  wire logic analog,
   input  wire logic osc_owned,
   input  wire logic pin_in,
   output logic      pin_out,
   output logic      pin_oe,
   output logic      read_level
);

   // ****************************************************************
   // Pin logic
   // ****************************************************************
   // Direction stays in force even for analog pins; software keeps it set.
   always_comb
   begin
      pin_out    = latch;
      pin_oe     = ~dir_in & ~osc_owned;
      read_level = pin_in & ~analog & ~osc_owned;
   end

endmodule : podc_port_pin

// File: podc_top.sv
/*
 * Port A and peripheral open-drain pad control, with an Avalon-MM slave.
 * Assumes synchronous pin inputs, one clock and an active-low async reset.
 */
// Our own choices: the address map and the Avalon-MM slave port.
// Notes on behaviour
// - Open-drain enable 1 gives open-drain output, 0 gives push-pull drive.
// - Register one: serial1 bit 7, capture2 bit 6, capture1 bit 5, serial2 bit 0.
// - Register two holds capture units 10 down to 3 in bits 7 to 0.
// - Small-memory variants lack capture 10 and 9 enable bits.
// - Register three: uart2 bit 7, uart1 bit 6, bits 5 to 1 zero.
// - Register three bit 0 connects the pulse-delay input from port F pin 1.
// - Analog-select set makes the pin analog, clear makes it digital.
// - Port A has eight pins, eight direction bits and eight latch bits.
// - Pins 5 and 3 to 0 follow the analog-select register.
// - Direction bits control analog pins too; software keeps them set.
// - Reset makes pins 5 and 3 to 0 analog, reading zero; pin 4 input.
// - External oscillator modes take pins 6 and 7; their bits read zero.
// - Internal oscillator mode frees pins 6 and 7 as digital I/O.
// - Pin 5 can feed timer 1 clock or timer 3 gate.
// - Direction 1 makes the pin input; 0 drives the latch bit.
// - Port reads return pin levels; port writes update the latch.
`timescale 1ns/1ps
module podc_top
   import podc_pkg::*;
#(
   parameter bit SMALL_MEMORY = 1'b0
)
(
   input  wire logic         ref_clk,
   input  wire logic         resetn,
   input  wire logic [3:0]   avs_address,
   input  wire logic         avs_read,
   input  wire logic         avs_write,
   input  wire logic [31:0]  avs_writedata,
   output logic [31:0]       avs_readdata,
   output logic              avs_waitrequest,
   input  wire logic         osc_internal,
   input  wire podc_periph_t periph_data,
   input  wire podc_periph_t periph_drive,
   output podc_periph_t      periph_pad_out,
   output podc_periph_t      periph_pad_oe,
   input  wire logic         port_f_pin1_in,
   output logic              charge_time_pulse_delay,
   input  wire logic [7:0]   port_a_in,
   output logic [7:0]        port_a_out,
   output logic [7:0]        port_a_oe,
   output logic [7:0]        port_a_analog,
   output logic              timer1_clock_in,
   output logic              timer3_gate_in
);

   // ****************************************************************
   // Register state
   // ****************************************************************
   localparam logic [7:0] OD2_MASK = SMALL_MEMORY ? OD2_MASK_SMALL : OD2_MASK_FULL;

   logic [7:0]  od1_q, od1_d, od2_q, od2_d, od3_q, od3_d;
   logic [7:0]  port_a_direction_q, port_a_direction_d;
   logic [7:0]  port_a_output_latch_q, port_a_output_latch_d;
   logic [7:0]  analog_select_reg1_q, analog_select_reg1_d;
   logic [7:0]  clk_cfg_q, clk_cfg_d;
   logic [31:0] rdata_q, rdata_d;
   logic        ack_q, ack_d;
   logic [7:0]  port_a_pin_levels;
   logic [7:0]  osc_owned;
   logic [7:0]  wdata;
   logic        wr_go;
   podc_req_t   req;

   always_comb
   begin
      req.read      = avs_read;
      req.write     = avs_write;
      req.address   = avs_address;
      req.writedata = avs_writedata[7:0];
   end

   // Pins 6 and 7 belong to the oscillator unless an internal one is chosen.
   assign osc_owned = osc_internal ? 8'h00 : OSC_PINS_MASK;
   assign wdata     = req.writedata;
   // A write lands only at the edge where waitrequest is seen low by the master.
   assign wr_go     = req.write & ack_q;

   // ****************************************************************
   // Bus slave: one wait state, then the answer
   // ****************************************************************
   // A single wait state keeps read data registered at the cost of one cycle.
   always_comb
   begin
      ack_d  = (req.read | req.write) & ~ack_q;
      rdata_d = 32'h0000_0000;
      case (req.address)
         OFS_OD_SERIAL_CAPTURE: rdata_d[7:0] = od1_q;
         OFS_OD_CAPTURE_UNITS:  rdata_d[7:0] = od2_q;
         OFS_OD_UART_PULSE:     rdata_d[7:0] = od3_q;
         OFS_PORT_A_PINS:       rdata_d[7:0] = port_a_pin_levels;
         OFS_PORT_A_LATCH:      rdata_d[7:0] = port_a_output_latch_q & ~osc_owned;
         OFS_PORT_A_DIR:        rdata_d[7:0] = port_a_direction_q & ~osc_owned;
         OFS_ANALOG_SEL1:       rdata_d[7:0] = analog_select_reg1_q;
         OFS_CLOCK_CFG:         rdata_d[7:0] = clk_cfg_q;
         default:               rdata_d = 32'h0000_0000;
      endcase
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign avs_readdata    = rdata_q;

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         ack_q   <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   // ****************************************************************
   // Writable registers
   // ****************************************************************
   always_comb
   begin
      od1_d = od1_q;
      od2_d = od2_q;
      od3_d = od3_q;
      port_a_direction_d    = port_a_direction_q;
      port_a_output_latch_d = port_a_output_latch_q;
      analog_select_reg1_d  = analog_select_reg1_q;
      clk_cfg_d = clk_cfg_q;
      if (wr_go)
      begin
         case (req.address)
            OFS_OD_SERIAL_CAPTURE: od1_d = wdata & OD1_MASK;
            OFS_OD_CAPTURE_UNITS:  od2_d = wdata & OD2_MASK;
            OFS_OD_UART_PULSE:     od3_d = wdata & OD3_MASK;
            OFS_PORT_A_PINS:       port_a_output_latch_d = wdata;
            OFS_PORT_A_LATCH:      port_a_output_latch_d = wdata;
            OFS_PORT_A_DIR:        port_a_direction_d = wdata;
            OFS_ANALOG_SEL1:       analog_select_reg1_d = wdata & ANALOG_A_MASK;
            OFS_CLOCK_CFG:         clk_cfg_d = wdata & CLK_CFG_MASK;
            default:               od1_d = od1_q;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         od1_q <= OD_RESET;
         od2_q <= OD_RESET;
         od3_q <= OD_RESET;
         port_a_direction_q    <= DIR_RESET;
         port_a_output_latch_q <= LATCH_RESET;
         analog_select_reg1_q  <= ANALOG_RESET;
         clk_cfg_q <= CLK_CFG_RESET;
      end
      else
      begin
         od1_q <= od1_d;
         od2_q <= od2_d;
         od3_q <= od3_d;
         port_a_direction_q    <= port_a_direction_d;
         port_a_output_latch_q <= port_a_output_latch_d;
         analog_select_reg1_q  <= analog_select_reg1_d;
         clk_cfg_q <= clk_cfg_d;
      end
   end

   // ****************************************************************
   // Port A pins
   // ****************************************************************
   assign port_a_analog = analog_select_reg1_q & ANALOG_A_MASK;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_pin
         podc_port_pin u_pin (
            .dir_in     (port_a_direction_q[gi]),
            .latch      (port_a_output_latch_q[gi]),
            .analog     (port_a_analog[gi]),
            .osc_owned  (osc_owned[gi]),
            .pin_in     (port_a_in[gi]),
            .pin_out    (port_a_out[gi]),
            .pin_oe     (port_a_oe[gi]),
            .read_level (port_a_pin_levels[gi])
         );
      end
   endgenerate

   // Timer inputs on pin 5 are taken only while software selects them.
   assign timer1_clock_in = clk_cfg_q[CLK_TIMER1_BIT] & port_a_in[5];
   assign timer3_gate_in  = clk_cfg_q[CLK_TIMER3_BIT] & port_a_in[5];
   assign charge_time_pulse_delay = od3_q[PDLY_BIT] & port_f_pin1_in;

   // ****************************************************************
   // Peripheral open-drain pads
   // ****************************************************************
   podc_periph_t od_en;
   always_comb
   begin
      od_en.sync_serial1 = od1_q[SER1_BIT];
      od_en.capture2     = od1_q[CAP2_BIT];
      od_en.capture1     = od1_q[CAP1_BIT];
      od_en.sync_serial2 = od1_q[SER2_BIT];
      od_en.capture10_3  = od2_q;
      od_en.uart2        = od3_q[UART2_BIT];
      od_en.uart1        = od3_q[UART1_BIT];
   end

   generate
      for (gi = 0; gi < $bits(podc_periph_t); gi++)
      begin : g_od
         podc_od_pad u_pad (
            .od_en    (od_en[gi]),
            .data     (periph_data[gi]),
            .drive_en (periph_drive[gi]),
            .pad_out  (periph_pad_out[gi]),
            .pad_oe   (periph_pad_oe[gi])
         );
      end
   endgenerate

   // ****************************************************************
   // Checks
   // ****************************************************************
   od_reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (od1_q[4:1] == 4'h0) && (od3_q[5:1] == 5'h00))
      else $error("reserved open-drain bits set");
   od_write_lands_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (wr_go && req.address == OFS_OD_UART_PULSE)
      |=> (od3_q == ($past(wdata) & OD3_MASK)))
      else $error("register three write lost");
   small_mem_bits_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      SMALL_MEMORY |-> (od2_q[7:6] == 2'b00))
      else $error("capture 10 or 9 enable present");
   od_high_float_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (od_en.uart1 && periph_data.uart1) |-> !periph_pad_oe.uart1)
      else $error("open-drain pad drove high");
   push_pull_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (!od_en.uart2 && periph_drive.uart2)
      |-> (periph_pad_oe.uart2 && periph_pad_out.uart2 == periph_data.uart2))
      else $error("push-pull drive wrong");
   analog_reads_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      port_a_analog[0] |-> !port_a_pin_levels[0])
      else $error("analog pin read non-zero");
   osc_pins_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (!osc_internal && ack_q && req.read && req.address == OFS_PORT_A_DIR)
      |-> (avs_readdata[7:6] == 2'b00))
      else $error("oscillator pin bits not zero");
   dir_drive_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (!port_a_direction_q[4])
      |-> (port_a_oe[4] && port_a_out[4] == port_a_output_latch_q[4]))
      else $error("output pin not driving latch");
   pulse_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      !od3_q[PDLY_BIT] |-> !charge_time_pulse_delay)
      else $error("pulse delay not disconnected");
   od_low_only_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      od_en.capture1 |-> !periph_pad_out.capture1)
      else $error("open-drain pad drove a level");

   // ****************************************************************
   // Bus and register checks
   // ****************************************************************
   // Each write is tied to the edge at which waitrequest is seen low.
   bus_one_wait_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      avs_waitrequest |=> !avs_waitrequest)
      else $error("second wait state inserted");

   latch_write_lands_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (wr_go && (req.address == OFS_PORT_A_PINS))
      |=> (port_a_output_latch_q == $past(wdata)))
      else $error("port write missed the latch");

   dir_write_lands_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (wr_go && (req.address == OFS_PORT_A_DIR))
      |=> (port_a_direction_q == $past(wdata)))
      else $error("direction write lost");

   analog_write_lands_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (wr_go && (req.address == OFS_ANALOG_SEL1))
      |=> (analog_select_reg1_q == ($past(wdata) & ANALOG_A_MASK)))
      else $error("analog select write lost");

   osc_pins_float_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      !osc_internal |-> (port_a_oe[7:6] == 2'b00))
      else $error("oscillator pin driven");

   osc_latch_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (!osc_internal && ack_q && req.read && (req.address == OFS_PORT_A_LATCH))
      |-> (avs_readdata[7:6] == 2'b00))
      else $error("oscillator latch bits not zero");

   timer_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      !clk_cfg_q[CLK_TIMER1_BIT] |-> !timer1_clock_in)
      else $error("timer clock passed while off");

   od_reset_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      $rose(resetn) |-> ((od1_q == OD_RESET) && (od2_q == OD_RESET) && (od3_q == OD_RESET)))
      else $error("open-drain reset not zero");

   port_reset_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      $rose(resetn) |-> ((port_a_analog == ANALOG_RESET) && (port_a_oe == 8'h00)))
      else $error("port reset state wrong");

   port_out_latch_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      port_a_out == port_a_output_latch_q)
      else $error("port drive differs from latch");

endmodule : podc_top

// File: podc_board.sv
/*
 * Board model for the pad block: external drivers on port A and pull-ups
 * on the peripheral open-drain lines.
 * Assumes the pad enables come from the block under test.
 */
`timescale 1ns/1ps
module podc_board
   import podc_pkg::*;
(
   input  wire logic         ref_clk,
   input  wire logic [7:0]   pa_out,
   input  wire logic [7:0]   pa_oe,
   input  wire logic [7:0]   ext_en,
   input  wire logic [7:0]   ext_val,
   output logic [7:0]        pa_in,
   input  wire podc_periph_t pd_out,
   input  wire podc_periph_t pd_oe,
   output podc_periph_t      pd_level
);
   // A floating pin toggles each cycle, so a stale level never passes for a driven one.
   logic [7:0] float_q;
   initial float_q = 8'h55;
   always @(posedge ref_clk) float_q <= ~float_q;
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         pa_in[i] = pa_oe[i] ? pa_out[i] : (ext_en[i] ? ext_val[i] : float_q[i]);
      end
   end
   // Released open-drain lines rise through the board pull-up.
   assign pd_level = (pd_oe & pd_out) | ~pd_oe;
endmodule : podc_board

// File: port_a_open_drain_pad_ctrl_tb.sv
/*
 * Self-checking bench for the port A and open-drain pad block.
 * Assumes an Avalon slave with waitrequest; the bench waits for its answer.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module port_a_open_drain_pad_ctrl_tb;
   import podc_pkg::*;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rq, rd_s, rs;
   logic avs_waitrequest, pdly, t1, t3;
   logic osc_internal = 1'b1;
   logic pf1 = 1'b0;
   logic [13:0] da = 14'h0;
   logic [13:0] dr = 14'h0;
   podc_periph_t pad_out, pad_oe, level, e;
   logic [7:0] pa_in, pa_out, pa_oe, pa_an;
   logic [7:0] ext_en = 8'h00;
   logic [7:0] ext_val = 8'h00;
   int fail_count = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [7:0] rst_exp [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h2f, 8'h00};
   always #2.5 ref_clk = ~ref_clk;
   podc_top #(.SMALL_MEMORY(1'b0)) DUT (.ref_clk(ref_clk), .resetn(resetn),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .osc_internal(osc_internal),
      .periph_data(podc_periph_t'(da)), .periph_drive(podc_periph_t'(dr)),
      .periph_pad_out(pad_out), .periph_pad_oe(pad_oe), .port_f_pin1_in(pf1),
      .charge_time_pulse_delay(pdly), .port_a_in(pa_in), .port_a_out(pa_out),
      .port_a_oe(pa_oe), .port_a_analog(pa_an), .timer1_clock_in(t1),
      .timer3_gate_in(t3));
   podc_board BRD (.ref_clk(ref_clk), .pa_out(pa_out), .pa_oe(pa_oe), .ext_en(ext_en),
      .ext_val(ext_val), .pa_in(pa_in), .pd_out(pad_out), .pd_oe(pad_oe),
      .pd_level(level));
   // Small-memory variant on the same bus; only its read data is watched.
   podc_top #(.SMALL_MEMORY(1'b1)) DUT_S (.ref_clk(ref_clk), .resetn(resetn),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(rd_s), .avs_waitrequest(),
      .osc_internal(osc_internal), .periph_data(podc_periph_t'(da)),
      .periph_drive(podc_periph_t'(dr)), .periph_pad_out(), .periph_pad_oe(),
      .port_f_pin1_in(pf1), .charge_time_pulse_delay(), .port_a_in(pa_in),
      .port_a_out(), .port_a_oe(), .port_a_analog(), .timer1_clock_in(),
      .timer3_gate_in());
   // ****************************************************************
   // Bus and report tasks
   // ****************************************************************
   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   // Holds the request until waitrequest is seen low at an edge.
   task automatic xfer(input bit we, input logic [3:0] a, input logic [7:0] d);
      logic w;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= we;
      avs_read <= ~we;
      do
      begin
         @(posedge ref_clk);
         w = avs_waitrequest;
         rq = avs_readdata;
         rs = rd_s;
      end
      while (w !== 1'b0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : xfer
   task automatic rchk(input logic [3:0] a, input logic [7:0] x);
      xfer(1'b0, a, 8'h00);
      `CHK("register", {24'h0, x}, rq)
   endtask : rchk
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         fail_count++;
         summarize();
      end
   end
   // ****************************************************************
   // Tests
   // ****************************************************************
   initial
   begin
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      for (int i = 0; i < 10; i++)
         if (i != 3) rchk(4'(i), (i < 8) ? rst_exp[i] : 8'h00);
      `CHK("analog", 8'h2f, pa_an)
      `CHK("port oe", 8'h00, pa_oe)
      // Reserved bits must read zero after writing all ones (8'hfe to register three).
      xfer(1'b1, OFS_OD_SERIAL_CAPTURE, 8'hff);
      xfer(1'b1, OFS_OD_CAPTURE_UNITS, 8'hff);
      xfer(1'b1, OFS_OD_UART_PULSE, 8'hfe);
      rchk(OFS_OD_SERIAL_CAPTURE, 8'he1);
      rchk(OFS_OD_CAPTURE_UNITS, 8'hff);
      `CHK("small map", 32'h0000_003f, rs)
      rchk(OFS_OD_UART_PULSE, 8'hc0);
      xfer(1'b1, 4'h9, 8'h5a);
      rchk(4'h9, 8'h00);
      @(posedge ref_clk);
      da <= 14'h1555;
      dr <= 14'h3cf0;
      @(negedge ref_clk);
      `CHK("pad oe", 14'(dr & ~da), 14'(pad_oe))
      `CHK("pad out", 14'h0, 14'(pad_out))
      `CHK("pad level", 14'(~(dr & ~da)), 14'(level))
      xfer(1'b1, OFS_OD_SERIAL_CAPTURE, 8'h21);
      xfer(1'b1, OFS_OD_CAPTURE_UNITS, 8'h04);
      xfer(1'b1, OFS_OD_UART_PULSE, 8'h41);
      da <= 14'h3fff;
      dr <= 14'h3fff;
      e = '1;
      e.capture1 = 1'b0;
      e.sync_serial2 = 1'b0;
      e.uart1 = 1'b0;
      e.capture10_3[2] = 1'b0;
      @(negedge ref_clk);
      `CHK("pad oe map", e, pad_oe)
      `CHK("pad out map", e, pad_out)
      for (int i = 0; i < 3; i++)
      begin
         @(posedge ref_clk);
         pf1 <= (i != 0);
         if (i == 2) xfer(1'b1, OFS_OD_UART_PULSE, 8'h00);
         @(negedge ref_clk);
         `CHK("pulse delay", (i == 1), pdly)
      end
      xfer(1'b1, OFS_ANALOG_SEL1, 8'h00);
      xfer(1'b1, OFS_PORT_A_DIR, 8'h0f);
      xfer(1'b1, OFS_PORT_A_LATCH, 8'ha5);
      ext_en <= 8'h0f;
      ext_val <= 8'h06;
      @(negedge ref_clk);
      `CHK("analog clear", 8'h00, pa_an)
      `CHK("port oe dir", 8'hf0, pa_oe)
      `CHK("port out", 8'ha5, pa_out)
      rchk(OFS_PORT_A_PINS, 8'ha6);
      xfer(1'b1, OFS_PORT_A_PINS, 8'h3c);
      rchk(OFS_PORT_A_LATCH, 8'h3c);
      xfer(1'b1, OFS_ANALOG_SEL1, 8'hff);
      rchk(OFS_ANALOG_SEL1, 8'h2f);
      rchk(OFS_PORT_A_PINS, 8'h10);
      xfer(1'b1, OFS_PORT_A_DIR, 8'h00);
      @(negedge ref_clk);
      `CHK("analog oe", 8'hff, pa_oe)
      osc_internal <= 1'b0;
      rchk(OFS_PORT_A_LATCH, 8'h3c);
      xfer(1'b1, OFS_PORT_A_DIR, 8'hff);
      rchk(OFS_PORT_A_DIR, 8'h3f);
      xfer(1'b1, OFS_PORT_A_LATCH, 8'hff);
      rchk(OFS_PORT_A_LATCH, 8'h3f);
      xfer(1'b1, OFS_PORT_A_DIR, 8'h00);
      @(negedge ref_clk);
      `CHK("osc oe", 8'h3f, pa_oe)
      @(posedge ref_clk);
      osc_internal <= 1'b1;
      @(negedge ref_clk);
      `CHK("int osc oe", 8'hff, pa_oe)
      xfer(1'b1, OFS_PORT_A_DIR, 8'hff);
      xfer(1'b1, OFS_ANALOG_SEL1, 8'h00);
      ext_en <= 8'h20;
      ext_val <= 8'h20;
      for (int i = 1; i < 3; i++)
      begin
         xfer(1'b1, OFS_CLOCK_CFG, 8'(i));
         @(negedge ref_clk);
         `CHK("timer1 clock", (i == 1), t1)
         `CHK("timer3 gate", (i == 2), t3)
      end
      summarize();
   end
endmodule : port_a_open_drain_pad_ctrl_tb
